// file: rtl/lbfr_defs.svh
// Offsets, field positions, reset values and timing counts of the low-bus fault response block
`ifndef LBFR_DEFS_SVH
`define LBFR_DEFS_SVH
`define LBFR_CTRL1_ADDR 8'hB0
`define LBFR_RESP_ADDR 8'hB1
`define LBFR_STATUS_ADDR 8'hD2
`define LBFR_RESP_RESET 8'h00
`define LBFR_CTRL1_RESET 8'h00
`define LBFR_CTRL1_INDIV_BIT 7
`define LBFR_CTRL1_CLEAR_BIT 6
`define LBFR_OOV_LSB 0
`define LBFR_OUV_LSB 2
`define LBFR_IOV_LSB 4
`define LBFR_IUV_LSB 6
`define LBFR_ST_OOV_BIT 0
`define LBFR_ST_OUV_BIT 1
`define LBFR_ST_IOV_BIT 2
`define LBFR_ST_IUV_BIT 3
`define LBFR_HICCUP_MS 500
`define LBFR_CLK_MHZ 125
`define LBFR_HICCUP_CYCLES (`LBFR_HICCUP_MS * 1000 * `LBFR_CLK_MHZ)
`endif

// file: rtl/lbfr_pkg.sv
// Types shared by the low-bus fault response block
package lbfr_pkg;
    typedef enum logic [1:0] {
        LBFR_FLAG = 2'b00,
        LBFR_HICCUP = 2'b01,
        LBFR_LATCH = 2'b10,
        LBFR_FLAG_ALT = 2'b11
    } lbfr_resp_t;

    typedef struct packed {
        logic in_uv;
        logic in_ov;
        logic out_uv;
        logic out_ov;
    } lbfr_faults_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } lbfr_reg_wr_t;
endpackage

// file: rtl/lbfr_channel.sv
// One fault channel: comparison, response decode and switching-stop state
`timescale 1ns/1ps
`default_nettype none
`include "lbfr_defs.svh"
module lbfr_channel #(
    parameter int unsigned HICCUP_CYCLES = `LBFR_HICCUP_CYCLES,
    parameter int unsigned VW = 12,
    parameter bit IS_OV = 1'b1
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [VW-1:0] i_level,
    input wire logic [VW-1:0] i_threshold,
    input wire logic [1:0] i_resp,
    input wire logic i_restart,
    output logic o_fault,
    output logic o_stop
);
    typedef enum logic [1:0] {
        CH_RUN = 2'b00,
        CH_HICCUP = 2'b01,
        CH_LATCH = 2'b10
    } lbfr_ch_state_t;

    lbfr_ch_state_t state;
    lbfr_ch_state_t next_state;
    logic [31:0] wait_cnt;
    logic [31:0] next_wait_cnt;

    // Strict compare: a level sitting on the threshold is not a fault
    assign o_fault = IS_OV ? (i_level > i_threshold) : (i_level < i_threshold);
    // Taken from the next state so switching halts on the same edge that records the fault
    assign o_stop = (next_state != CH_RUN);

    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        unique case (state)
            CH_RUN: begin
                next_wait_cnt = 32'h0;
                if (o_fault && i_resp == lbfr_pkg::LBFR_HICCUP) begin
                    next_state = CH_HICCUP;
                end else if (o_fault && i_resp == lbfr_pkg::LBFR_LATCH) begin
                    next_state = CH_LATCH;
                end
            end
            CH_HICCUP: begin
                if (o_fault) begin
                    next_wait_cnt = 32'h0;
                end else if (wait_cnt >= HICCUP_CYCLES - 1) begin
                    next_state = CH_RUN;
                    next_wait_cnt = 32'h0;
                end else begin
                    next_wait_cnt = wait_cnt + 32'h1;
                end
            end
            CH_LATCH: begin
                if (i_restart) begin
                    next_state = CH_RUN;
                end
            end
            default: begin
                next_state = CH_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state <= CH_RUN;
            wait_cnt <= 32'h0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
        end
    end
endmodule // lbfr_channel
`default_nettype wire

// file: rtl/lbfr_top.sv
// Low-voltage bus fault response register and fault handling
`timescale 1ns/1ps
`default_nettype none
`include "lbfr_defs.svh"
// Operation
// - Response register at B1h, read/write, resets to 00h.
// - Fields: 7:6 in UV, 5:4 in OV, 3:2 out UV, 1:0 out OV.
// - Fields apply only when individual enable set; else mode pin response.
// - Fault sets status bit 0 out OV, 1 out UV, 2 in OV.
// - Any detected fault drives the active-low fault flag low.
// - Code 00 flags only; switching continues.
// - Hiccup or latch codes stop all phases together with flagging.
// - Hiccup restarts switching 500 ms after the fault clears.
// - Latch-off holds until switching enable or chip enable toggles.
// - Code 11 behaves exactly as code 00.
// - OV above first OV threshold; UV below first UV threshold.
// - Clear bit 1 then 0 clears status; persisting faults set again.
module lbfr_top #(
    parameter int unsigned HICCUP_CYCLES = `LBFR_HICCUP_CYCLES,
    parameter int unsigned VW = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire lbfr_pkg::lbfr_reg_wr_t i_reg_wr,
    input wire logic [7:0] i_reg_rd_addr,
    output logic [7:0] o_reg_rd_data,
    input wire logic [1:0] i_mode_resp,
    input wire logic i_pwm_en,
    input wire logic [VW-1:0] i_out_level,
    input wire logic [VW-1:0] i_in_level,
    input wire logic [VW-1:0] i_out_ov_thr,
    input wire logic [VW-1:0] i_out_uv_thr,
    input wire logic [VW-1:0] i_in_ov_thr,
    input wire logic [VW-1:0] i_in_uv_thr,
    output lbfr_pkg::lbfr_faults_t o_status,
    output logic o_fault_flag_n,
    output logic o_fault_flag_oe,
    output logic o_pwm_stop
);
    logic [7:0] resp;
    logic [7:0] next_resp;
    logic indiv_en;
    logic next_indiv_en;
    logic clear;
    logic next_clear;
    logic pwm_en_q;
    lbfr_pkg::lbfr_faults_t status;
    lbfr_pkg::lbfr_faults_t next_status;
    lbfr_pkg::lbfr_faults_t fault;
    lbfr_pkg::lbfr_faults_t stop;
    logic [7:0] next_rd_data;
    logic restart;
    logic next_flag_oe;
    logic next_pwm_stop;

    // Picks field or mode-pin code; codes 00 and 11 both give flag-only in the channel
    function automatic logic [1:0] lbfr_sel(input logic en, input logic [1:0] field,
                                            input logic [1:0] mode);
        return en ? field : mode;
    endfunction

    // Either edge of switching enable counts as the toggle that releases a latch
    assign restart = (i_pwm_en != pwm_en_q);

    lbfr_channel #(.HICCUP_CYCLES(HICCUP_CYCLES), .VW(VW), .IS_OV(1'b1)) u_out_ov (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_out_level),
        .i_threshold(i_out_ov_thr),
        .i_resp(lbfr_sel(indiv_en, resp[`LBFR_OOV_LSB +: 2], i_mode_resp)),
        .i_restart(restart),
        .o_fault(fault.out_ov),
        .o_stop(stop.out_ov)
    );
    lbfr_channel #(.HICCUP_CYCLES(HICCUP_CYCLES), .VW(VW), .IS_OV(1'b0)) u_out_uv (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_out_level),
        .i_threshold(i_out_uv_thr),
        .i_resp(lbfr_sel(indiv_en, resp[`LBFR_OUV_LSB +: 2], i_mode_resp)),
        .i_restart(restart),
        .o_fault(fault.out_uv),
        .o_stop(stop.out_uv)
    );
    lbfr_channel #(.HICCUP_CYCLES(HICCUP_CYCLES), .VW(VW), .IS_OV(1'b1)) u_in_ov (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_in_level),
        .i_threshold(i_in_ov_thr),
        .i_resp(lbfr_sel(indiv_en, resp[`LBFR_IOV_LSB +: 2], i_mode_resp)),
        .i_restart(restart),
        .o_fault(fault.in_ov),
        .o_stop(stop.in_ov)
    );
    lbfr_channel #(.HICCUP_CYCLES(HICCUP_CYCLES), .VW(VW), .IS_OV(1'b0)) u_in_uv (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_in_level),
        .i_threshold(i_in_uv_thr),
        .i_resp(lbfr_sel(indiv_en, resp[`LBFR_IUV_LSB +: 2], i_mode_resp)),
        .i_restart(restart),
        .o_fault(fault.in_uv),
        .o_stop(stop.in_uv)
    );

    always_comb begin
        next_resp = resp;
        next_indiv_en = indiv_en;
        next_clear = clear;
        if (i_reg_wr.wr && i_reg_wr.addr == `LBFR_RESP_ADDR) begin
            next_resp = i_reg_wr.data;
        end
        if (i_reg_wr.wr && i_reg_wr.addr == `LBFR_CTRL1_ADDR) begin
            next_indiv_en = i_reg_wr.data[`LBFR_CTRL1_INDIV_BIT];
            next_clear = i_reg_wr.data[`LBFR_CTRL1_CLEAR_BIT];
        end
    end

    // Clear held high keeps status at zero; set resumes the cycle after clear drops
    always_comb begin
        if (clear) begin
            next_status = '0;
        end else begin
            next_status = status | fault;
        end
    end

    always_comb begin
        next_flag_oe = |next_status;
        next_pwm_stop = |stop;
    end

    always_comb begin
        unique case (i_reg_rd_addr)
            `LBFR_RESP_ADDR: next_rd_data = resp;
            `LBFR_CTRL1_ADDR: next_rd_data = {indiv_en, clear, 6'h00};
            `LBFR_STATUS_ADDR: next_rd_data = {4'h0, status};
            default: next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            resp <= `LBFR_RESP_RESET;
            indiv_en <= 1'b0;
            clear <= 1'b0;
            status <= '0;
            // Tracks the pin in reset so release shows no false toggle
            pwm_en_q <= i_pwm_en;
            o_reg_rd_data <= 8'h00;
            o_status <= '0;
            o_fault_flag_n <= 1'b1;
            o_fault_flag_oe <= 1'b0;
            o_pwm_stop <= 1'b0;
        end else begin
            resp <= next_resp;
            indiv_en <= next_indiv_en;
            clear <= next_clear;
            status <= next_status;
            pwm_en_q <= i_pwm_en;
            o_reg_rd_data <= next_rd_data;
            o_status <= next_status;
            // Open drain: only ever pulls low, flag follows status in the same cycle
            o_fault_flag_n <= 1'b0;
            o_fault_flag_oe <= next_flag_oe;
            o_pwm_stop <= next_pwm_stop;
        end
    end
endmodule // lbfr_top
`default_nettype wire

// file: bench/lbfr_host.sv
// Controller model: register writes, reads and switching enable
`timescale 1ns/1ps
`default_nettype none
module lbfr_host (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rd_data,
    output var lbfr_pkg::lbfr_reg_wr_t o_reg_wr,
    output var logic [7:0] o_rd_addr,
    output var logic o_pwm_en
);
    initial begin
        o_reg_wr = '{1'b0, 8'h00, 8'h00};
        o_rd_addr = 8'h00;
        o_pwm_en = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_core_clk);
        o_reg_wr = '{1'b1, a, v};
        @(negedge i_core_clk);
        // Idle lines carry the inverse so stale data never looks valid
        o_reg_wr = '{1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_rd_addr = a;
        @(negedge i_core_clk);
        d = i_rd_data;
    endtask
    task automatic toggle();
        @(negedge i_core_clk);
        o_pwm_en = ~o_pwm_en;
    endtask
endmodule // lbfr_host
`default_nettype wire

// file: bench/lbfr_top_props.sv
// Port checker for the low-bus fault response block
`timescale 1ns/1ps
`default_nettype none
module lbfr_props #(parameter int unsigned HICCUP_CYCLES = 20, VW = 12) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire lbfr_pkg::lbfr_reg_wr_t i_reg_wr,
    input wire logic [7:0] i_reg_rd_addr,
    input wire logic [7:0] o_reg_rd_data,
    input wire logic i_pwm_en,
    input wire logic [VW-1:0] i_out_level,
    input wire logic [VW-1:0] i_out_ov_thr,
    input wire logic [VW-1:0] i_out_uv_thr,
    input wire lbfr_pkg::lbfr_faults_t o_status,
    input wire logic o_fault_flag_oe,
    input wire logic o_pwm_stop
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire logic clr_wr = i_reg_wr.wr && i_reg_wr.addr == 8'hB0 && i_reg_wr.data[6];
    // Consecutive cycles with switching stopped
    logic [31:0] stop_len;
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stop_len <= 32'h0;
        end else begin
            stop_len <= o_pwm_stop ? stop_len + 32'h1 : 32'h0;
        end
    end
    rst_vals_a: assert property (
        $rose(i_rst_n) |-> o_status == 4'h0 && !o_pwm_stop) else $error("reset state");
    flag_follow_a: assert property (
        o_fault_flag_oe == (o_status != 4'h0)) else $error("flag vs status");
    out_ov_a: assert property (
        $rose(o_status.out_ov) |-> $past(i_out_level > i_out_ov_thr)) else $error("out ov");
    out_uv_a: assert property (
        $rose(o_status.out_uv) |-> $past(i_out_level < i_out_uv_thr)) else $error("out uv");
    clear_only_a: assert property (
        $fell(o_status != 4'h0) |-> $past(clr_wr) || $past(clr_wr, 2)) else $error("clear");
    stop_cause_a: assert property (
        $rose(o_pwm_stop) |-> o_status != 4'h0) else $error("stop cause");
    stop_hold_a: assert property (
        $fell(o_pwm_stop) |-> stop_len >= HICCUP_CYCLES || $past(i_pwm_en) != $past(i_pwm_en, 2))
        else $error("stop too short");
    unmapped_zero_a: assert property (
        !(i_reg_rd_addr inside {8'hB0, 8'hB1, 8'hD2}) |=> o_reg_rd_data == 8'h00)
        else $error("unmapped read");
endmodule // lbfr_props
bind lbfr_top lbfr_props #(.HICCUP_CYCLES(HICCUP_CYCLES), .VW(VW)) u_props (.i_core_clk,
    .i_rst_n, .i_reg_wr, .i_reg_rd_addr, .o_reg_rd_data, .i_pwm_en, .i_out_level, .i_out_ov_thr,
    .i_out_uv_thr, .o_status, .o_fault_flag_oe, .o_pwm_stop);
`default_nettype wire

// file: bench/tb_top.sv
// Random and directed bench for the low-bus fault response block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int HC = 20;
    localparam logic [23:0] FLV [4] = '{24'hFFF800, 24'h000800, 24'h800FFF, 24'h800000};
    localparam logic [7:0] ADR [4] = '{8'hB1, 8'hB0, 8'hD2, 8'h5A};
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] code;
    logic [23:0] lv = 24'h800800;
    logic [15:0] seed = 16'h003F;
    logic [7:0] d, rd_addr, rd_data;
    logic [3:0] exp_st = 4'h0;
    logic indiv = 1'b0;
    logic pwm_en, oe, stop, flag_n;
    lbfr_pkg::lbfr_reg_wr_t reg_wr;
    lbfr_pkg::lbfr_faults_t st;
    int ch, err_total = 0, checks = 0;
    wire logic flag_pin = oe ? flag_n : 1'b1;
    always #4 i_core_clk = ~i_core_clk;
    lbfr_host host (.i_core_clk, .i_rd_data(rd_data), .o_reg_wr(reg_wr), .o_rd_addr(rd_addr),
        .o_pwm_en(pwm_en));
    lbfr_top #(.HICCUP_CYCLES(HC), .VW(12)) dut (.i_core_clk, .i_rst_n, .i_reg_wr(reg_wr),
        .i_reg_rd_addr(rd_addr), .o_reg_rd_data(rd_data), .i_mode_resp(mode), .i_pwm_en(pwm_en),
        .i_out_level(lv[23:12]), .i_in_level(lv[11:0]), .i_out_ov_thr(12'hC00),
        .i_out_uv_thr(12'h400), .i_in_ov_thr(12'hC00), .i_in_uv_thr(12'h400), .o_status(st),
        .o_fault_flag_n(flag_n), .o_fault_flag_oe(oe), .o_pwm_stop(stop));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic clear();
        host.wr(8'hB0, {indiv, 7'h40});
        host.wr(8'hB0, {indiv, 7'h00});
        cyc(3);
    endtask
    function automatic logic [3:0] flt(input logic [23:0] v);
        return {v[11:0] < 12'h400, v[11:0] > 12'hC00, v[23:12] < 12'h400, v[23:12] > 12'hC00};
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        err_total++;
        results();
    end
    initial begin
        cyc(6);
        i_rst_n = 1'b1;
        for (int a = 0; a < 4; a++) begin
            host.rd(ADR[a], d);
            chk(d, 8'h00);
        end
        chk(8'({stop, oe, flag_pin}), 8'h01);
        // Pin says flag only, so random fields must never stop switching
        repeat (12) begin
            seed = lfsr(seed);
            host.wr(8'hB1, seed[7:0]);
            host.rd(8'hB1, d);
            chk(d, seed[7:0]);
            lv = {seed, seed[11:4]};
            exp_st |= flt(lv);
            host.rd(8'hD2, d);
            chk(d, {4'h0, exp_st});
            chk(8'(stop), 8'h00);
        end
        lv = 24'h800800;
        clear();
        chk(8'(st), 8'h00);
        for (int k = 0; k < 20; k++) begin
            ch = k < 16 ? k % 4 : 0;
            code = 2'(k < 16 ? k / 4 : k - 16);
            indiv = k < 16;
            // Pin is latch while the field rules and fields are hiccup while the pin rules, so the ruling code shows at the stop output
            mode = k < 16 ? 2'h2 : code;
            host.wr(8'hB1, k < 16 ? 8'(code) << (2 * ch) : 8'h55);
            host.wr(8'hB0, {indiv, 7'h00});
            lv = FLV[ch];
            cyc(3);
            chk(8'(st), 8'h01 << ch);
            chk(8'({flag_pin, stop}), {7'h00, code inside {2'h1, 2'h2}});
            lv = 24'h800800;
            cyc(HC + 6);
            chk(8'(stop), 8'(code == 2'h2));
            host.toggle();
            cyc(4);
            chk(8'(stop), 8'h00);
            clear();
            chk(8'({st, flag_pin}), 8'h01);
        end
        // Fault returning mid-hiccup restarts the quiet count; field 5:4 latches
        indiv = 1'b1;
        host.wr(8'hB1, 8'h24);
        host.wr(8'hB0, 8'h80);
        lv = FLV[1];
        cyc(3);
        lv = 24'h800800;
        cyc(HC / 2);
        lv = FLV[1];
        cyc(1);
        lv = 24'h800800;
        cyc(HC - 3);
        chk(8'(stop), 8'h01);
        cyc(6);
        chk(8'(stop), 8'h00);
        // A fault still present when clear returns to 0 is recorded again
        lv = FLV[3];
        clear();
        chk(8'({st, flag_pin}), 8'h10);
        lv = FLV[2];
        cyc(3);
        chk(8'({st, stop}), 8'h19);
        // Chip enable low releases the latch and restores register defaults
        lv = 24'h800800;
        i_rst_n = 1'b0;
        cyc(2);
        i_rst_n = 1'b1;
        host.rd(8'hB1, d);
        chk(d, 8'h00);
        // Levels sitting exactly on the thresholds are not faults
        lv = 24'hC00400;
        cyc(3);
        chk(8'({stop, st}), 8'h00);
        results();
    end
endmodule // tb_top
`default_nettype wire
